// *** hw/tap_pkg.sv ***
/*
 Constants, state encoding and timing figures for the test access port
 controller. Assumes a five-wire test port, test reset included, driven by an outside master.
*/
`default_nettype none
package tap_pkg;
    // Gray codes along the usual path through the diagram
    typedef enum logic [3:0] {
        ST_RESET   = 4'h0,
        ST_IDLE    = 4'h1,
        ST_SEL_DR  = 4'h3,
        ST_CAP_DR  = 4'h2,
        ST_SH_DR   = 4'h6,
        ST_EX1_DR  = 4'h7,
        ST_PAU_DR  = 4'h5,
        ST_EX2_DR  = 4'h4,
        ST_UPD_DR  = 4'hC,
        ST_SEL_IR  = 4'hD,
        ST_CAP_IR  = 4'hF,
        ST_SH_IR   = 4'hE,
        ST_EX1_IR  = 4'hA,
        ST_PAU_IR  = 4'hB,
        ST_EX2_IR  = 4'h9,
        ST_UPD_IR  = 4'h8
    } tap_state_e;

    localparam int          STATE_W      = 4;
    localparam int          ID_W         = 32;
    // Identification value is arbitrary; bit 0 must be one
    localparam logic [31:0] ID_VALUE     = 32'h0000_0001;
    localparam int          SYNC_STAGES  = 2;
    localparam int          CLK_SYS_HZ   = 10_000_000;
    localparam int          RESET_HIGHS  = 5;
endpackage : tap_pkg
`default_nettype wire

// *** hw/level_sync.sv ***
/*
 Two flip-flop synchroniser for a single level.
 Assumes the input is stable long enough for the destination clock.
*/
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int STAGES = 2
) (
    // Destination clock
    input  wire logic i_clk,
    // Level from another domain
    input  wire logic i_async,
    output logic      o_sync
);
    logic [STAGES-1:0] chain_q;

    always_ff @(posedge i_clk) begin
        chain_q <= {chain_q[STAGES-2:0], i_async};
    end

    assign o_sync = chain_q[STAGES-1];
endmodule : level_sync
`default_nettype wire

// *** hw/tap_controller.sv ***
/*
 Test access port controller: sixteen-state machine on the test clock,
 identification data register, and a system-clock view of the controller.
 Assumes an outside master drives test clock, mode select, data in and
 the active-low test reset; the test clock may stop between operations.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_controller #(
    parameter logic [tap_pkg::ID_W-1:0] ID_CODE = tap_pkg::ID_VALUE
) (
    // System clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_srst,
    // Test port pins
    input  wire logic                      i_tck,
    input  wire logic                      i_tms,
    input  wire logic                      i_tdi,
    input  wire logic                      i_trst_n,
    output logic                           o_tdo,
    output logic                           o_tdo_oe,
    // Test clock domain status
    output tap_pkg::tap_state_e            o_tap_state,
    output logic                           o_capture_dr,
    output logic                           o_update_dr,
    output logic                           o_update_ir,
    // System clock domain status
    output logic                           o_test_logic_en,
    output logic                           o_id_load_seen
);
    import tap_pkg::*;

    tap_state_e            state_q;
    tap_state_e            state_d;
    logic                  edge_seen_q;
    logic                  reset_tgl_q;
    logic [ID_W-1:0]       id_sh_q;
    logic                  tdo_q;
    logic                  tdo_oe_q;
    logic                  cap_dr_q;
    logic                  upd_dr_q;
    logic                  upd_ir_q;

    logic                  active_tck_q;
    logic                  active_sys;
    logic                  tgl_sys;
    logic                  tgl_seen_q;
    logic                  test_en_q;
    logic                  id_seen_q;

    // Next state from the mode select sampled at the rising test clock
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                if (i_tms) begin
                    state_d = ST_RESET;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (i_tms) begin
                    state_d = ST_SEL_DR;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_SEL_DR: begin
                if (i_tms) begin
                    state_d = ST_SEL_IR;
                end else begin
                    state_d = ST_CAP_DR;
                end
            end
            ST_CAP_DR: begin
                if (i_tms) begin
                    state_d = ST_EX1_DR;
                end else begin
                    state_d = ST_SH_DR;
                end
            end
            ST_SH_DR: begin
                if (i_tms) begin
                    state_d = ST_EX1_DR;
                end else begin
                    state_d = ST_SH_DR;
                end
            end
            ST_EX1_DR: begin
                if (i_tms) begin
                    state_d = ST_UPD_DR;
                end else begin
                    state_d = ST_PAU_DR;
                end
            end
            ST_PAU_DR: begin
                if (i_tms) begin
                    state_d = ST_EX2_DR;
                end else begin
                    state_d = ST_PAU_DR;
                end
            end
            ST_EX2_DR: begin
                if (i_tms) begin
                    state_d = ST_UPD_DR;
                end else begin
                    state_d = ST_SH_DR;
                end
            end
            ST_UPD_DR: begin
                if (i_tms) begin
                    state_d = ST_SEL_DR;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_SEL_IR: begin
                if (i_tms) begin
                    state_d = ST_RESET;
                end else begin
                    state_d = ST_CAP_IR;
                end
            end
            ST_CAP_IR: begin
                if (i_tms) begin
                    state_d = ST_EX1_IR;
                end else begin
                    state_d = ST_SH_IR;
                end
            end
            ST_SH_IR: begin
                if (i_tms) begin
                    state_d = ST_EX1_IR;
                end else begin
                    state_d = ST_SH_IR;
                end
            end
            ST_EX1_IR: begin
                if (i_tms) begin
                    state_d = ST_UPD_IR;
                end else begin
                    state_d = ST_PAU_IR;
                end
            end
            ST_PAU_IR: begin
                if (i_tms) begin
                    state_d = ST_EX2_IR;
                end else begin
                    state_d = ST_PAU_IR;
                end
            end
            ST_EX2_IR: begin
                if (i_tms) begin
                    state_d = ST_UPD_IR;
                end else begin
                    state_d = ST_SH_IR;
                end
            end
            ST_UPD_IR: begin
                if (i_tms) begin
                    state_d = ST_SEL_DR;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    // State register: rising test clock only, forced by test reset
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Each entry into reset flips a toggle for the system side on the entry
    // edge; an entry forced by test reset flips it at the first edge after
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            edge_seen_q <= 1'b0;
            reset_tgl_q <= 1'b0;
        end else begin
            edge_seen_q <= 1'b1;
            if ((state_d == ST_RESET) && (state_q != ST_RESET)) begin
                reset_tgl_q <= ~reset_tgl_q;
            end else if ((state_q == ST_RESET) && !edge_seen_q) begin
                reset_tgl_q <= ~reset_tgl_q;
            end
        end
    end

    // Identification register: loaded in reset and capture, shifted in shift
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            id_sh_q <= ID_CODE;
        end else if (state_d == ST_RESET) begin
            // Loaded on the entry edge itself, so a stopped test clock still finds it
            id_sh_q <= ID_CODE;
        end else begin
            case (state_q)
                ST_RESET: begin
                    id_sh_q <= ID_CODE;
                end
                ST_CAP_DR: begin
                    id_sh_q <= ID_CODE;
                end
                ST_SH_DR: begin
                    id_sh_q <= {i_tdi, id_sh_q[ID_W-1:1]};
                end
                default: begin
                    id_sh_q <= id_sh_q;
                end
            endcase
        end
    end

    // State strobes, held for one test clock period
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            cap_dr_q <= 1'b0;
            upd_dr_q <= 1'b0;
            upd_ir_q <= 1'b0;
        end else begin
            cap_dr_q <= (state_d == ST_CAP_DR);
            upd_dr_q <= (state_d == ST_UPD_DR);
            upd_ir_q <= (state_d == ST_UPD_IR);
        end
    end

    // Serial output changes on the falling test clock; quiet in reset
    always_ff @(negedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= id_sh_q[0];
            tdo_oe_q <= (state_q == ST_SH_DR);
        end
    end

    // Registered so that no decode glitch reaches the synchroniser
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            active_tck_q <= 1'b0;
        end else begin
            active_tck_q <= (state_d != ST_RESET);
        end
    end

    // Crossings into the system clock domain
    level_sync #(
        .STAGES (SYNC_STAGES)
    ) u_sync_active (
        .i_clk   (i_clk_sys),
        .i_async (active_tck_q),
        .o_sync  (active_sys)
    );

    level_sync #(
        .STAGES (SYNC_STAGES)
    ) u_sync_tgl (
        .i_clk   (i_clk_sys),
        .i_async (reset_tgl_q),
        .o_sync  (tgl_sys)
    );

    // Test logic enable as seen by the functional side
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            test_en_q <= 1'b0;
        end else begin
            test_en_q <= active_sys;
        end
    end

    // One-cycle pulse per change of the reset toggle, that is per entry into reset
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            // Level-matched so that leaving reset makes no false pulse
            tgl_seen_q <= tgl_sys;
            id_seen_q  <= 1'b0;
        end else begin
            tgl_seen_q <= tgl_sys;
            id_seen_q  <= (tgl_sys != tgl_seen_q);
        end
    end

    assign o_tdo           = tdo_q;
    assign o_tdo_oe        = tdo_oe_q;
    assign o_tap_state     = state_q;
    assign o_capture_dr    = cap_dr_q;
    assign o_update_dr     = upd_dr_q;
    assign o_update_ir     = upd_ir_q;
    assign o_test_logic_en = test_en_q;
    assign o_id_load_seen  = id_seen_q;
endmodule : tap_controller
`default_nettype wire

// *** bench/tap_controller_chk.sv ***
/*
 Checker for the test access port controller state walk and system view.
 Sees only the controller's ports; bound to every tap_controller.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_controller_chk (
    // Clocks and resets
    input wire logic                i_clk_sys,
    input wire logic                i_srst,
    input wire logic                i_tck,
    input wire logic                i_trst_n,
    // Observed signals
    input wire logic                i_tms,
    input wire tap_pkg::tap_state_e o_tap_state,
    input wire logic                o_test_logic_en,
    input wire logic                o_id_load_seen
);
    import tap_pkg::*;
    wire logic in_rst = (o_tap_state == ST_RESET);

    property p_five;
        @(posedge i_tck) disable iff (!i_trst_n) i_tms [*5] |=> in_rst;
    endproperty
    a_five: assert property (p_five) else $error("five highs missed reset");
    property p_hold;
        @(posedge i_tck) disable iff (!i_trst_n) in_rst && i_tms |=> in_rst;
    endproperty
    a_hold: assert property (p_hold) else $error("reset not held");
    property p_stray;
        @(posedge i_tck) disable iff (!i_trst_n) in_rst && !i_tms ##1 i_tms [*3] |=> in_rst;
    endproperty
    a_stray: assert property (p_stray) else $error("no return to reset");
    property p_idle;
        @(posedge i_tck) disable iff (!i_trst_n)
            o_tap_state == ST_IDLE |=> o_tap_state == ($past(i_tms) ? ST_SEL_DR : ST_IDLE);
    endproperty
    a_idle: assert property (p_idle) else $error("idle step wrong");
    property p_sel_ir;
        @(posedge i_tck) disable iff (!i_trst_n) o_tap_state == ST_SEL_IR && i_tms |=> in_rst;
    endproperty
    a_sel_ir: assert property (p_sel_ir) else $error("ir select step wrong");
    property p_trst;
        @(posedge i_clk_sys) disable iff (i_srst) !i_trst_n [*2] |-> in_rst;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset ignored");
    property p_off;
        @(posedge i_clk_sys) disable iff (i_srst) in_rst [*5] |-> !o_test_logic_en;
    endproperty
    a_off: assert property (p_off) else $error("test logic on in reset");
    property p_load;
        @(posedge i_clk_sys) disable iff (i_srst)
            $rose(in_rst) && i_trst_n |-> ##[0:6] o_id_load_seen;
    endproperty
    a_load: assert property (p_load) else $error("no id load seen");

    c_five: cover property (@(posedge i_tck) i_tms [*5] ##1 in_rst);
    c_stray: cover property (@(posedge i_tck) in_rst && !i_tms ##1 i_tms [*3] ##1 in_rst);
    c_load: cover property (@(posedge i_clk_sys) o_id_load_seen);
endmodule : tap_controller_chk

bind tap_controller tap_controller_chk u_chk (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_tck(i_tck), .i_trst_n(i_trst_n), .i_tms(i_tms),
    .o_tap_state(o_tap_state), .o_test_logic_en(o_test_logic_en),
    .o_id_load_seen(o_id_load_seen)
);
`default_nettype wire

// *** bench/tap_master.sv ***
/*
 Test port master model: test clock, mode select, data in, test reset.
 Assumes the bench calls step once per clock pulse; the clock idles low.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_master (
    // Test port pins
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_n
);
    // Power-up initialisation through test reset
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_trst_n = 1'b1;
        #20;
        o_trst_n = 1'b0;
    end

    // One 12 ns clock period, high for 6 ns; levels change 6 ns before the rising edge
    task automatic step(input logic m, input logic d);
        o_tms = m;
        o_tdi = d;
        #6 o_tck = 1'b1;
        #6 o_tck = 1'b0;
    endtask : step

    task automatic set_trst(input logic v);
        o_trst_n = v;
    endtask : set_trst
endmodule : tap_master
`default_nettype wire

// *** bench/tap_controller_reset_fsm_tb.sv ***
/*
 Testbench for the test access port controller.
 Assumes tap_master drives the test pins and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_controller_reset_fsm_tb;
    import tap_pkg::*;
    logic        clk, srst, tck, tms, tdi, trst_n, tdo, oe;
    logic        cap, udr, uir, en, idl;
    tap_state_e  st, cur;
    logic [31:0] sh, rnd;
    logic [5:0]  e, q[$];
    logic [1:0]  o;
    int          mismatches, n_checks;
    int          n_loads, nl;

    tap_master master (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
    tap_controller dut (
        .i_clk_sys(clk), .i_srst(srst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(oe), .o_tap_state(st),
        .o_capture_dr(cap), .o_update_dr(udr), .o_update_ir(uir), .o_test_logic_en(en),
        .o_id_load_seen(idl)
    );

    // Count identification load pulses on the system clock
    always @(negedge clk) begin
        if (idl === 1'b1) n_loads++;
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic tap_state_e nx(tap_state_e s, logic m);
        case (s)
            ST_RESET: return m ? ST_RESET : ST_IDLE;
            ST_IDLE: return m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR, ST_SH_DR: return m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: return m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: return m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: return m ? ST_UPD_DR : ST_SH_DR;
            ST_SEL_IR: return m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR, ST_SH_IR: return m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: return m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: return m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: return m ? ST_UPD_IR : ST_SH_IR;
            default: return m ? ST_SEL_DR : ST_IDLE;
        endcase
    endfunction : nx

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [3:0] x, input logic [3:0] y);
        n_checks++;
        if (y !== x) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, x, y);
        end
    endtask : chk

    // Note the expected outcome, then pulse the test clock once
    task automatic go(input logic m, input logic fast);
        if (!fast) @(negedge clk);
        rnd = lfsr(rnd);
        q.push_back({cur == ST_SH_DR, sh[0], nx(cur, m)});
        if (cur inside {ST_RESET, ST_CAP_DR}) sh = ID_VALUE;
        else if (cur == ST_SH_DR) sh = {rnd[0], sh[31:1]};
        cur = nx(cur, m);
        master.step(m, rnd[0]);
    endtask : go

    task automatic seq(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) go(v[i], 1'b0);
    endtask : seq

    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    // Compare each test clock edge with the oldest note
    initial forever begin
        @(posedge tck);
        o = {oe, tdo};
        #1;
        e = q.pop_front();
        chk("state", e[3:0], st);
        chk("oe", {3'h0, e[5]}, {3'h0, o[1]});
        if (e[5]) chk("tdo", {3'h0, e[4]}, {3'h0, o[0]});
        chk("strobes", {1'b0, e[3:0] == ST_CAP_DR, e[3:0] == ST_UPD_DR, e[3:0] == ST_UPD_IR}, {1'b0, cap, udr, uir});
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end

    initial begin
        srst = 1'b1;
        cur = ST_RESET;
        sh = ID_VALUE;
        rnd = 32'h6FFCF221;
        mismatches = 0;
        n_checks = 0;
        n_loads = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        master.set_trst(1'b1);
        // Random walk, cut every 25 steps by five highs
        for (int i = 0; i < 300; i++) begin
            rnd = lfsr(rnd);
            go(rnd[7], 1'b0);
            if (i % 25 == 24) begin
                seq(32'h1F, 5);
                chk("five", ST_RESET, st);
            end
        end
        // Hold, idle, capture, long shift, then both scan columns
        seq(32'h13, 7);
        repeat (40) go(1'b0, 1'b1);
        seq(32'h7769E9, 23);
        // Test reset in mid-shift, then the identification value again
        seq(32'h2, 4);
        chk("en", 4'h1, {3'h0, en});
        master.set_trst(1'b0);
        cur = ST_RESET;
        sh = ID_VALUE;
        repeat (3) @(negedge clk);
        chk("trst state", ST_RESET, st);
        chk("trst oe", 4'h0, {3'h0, oe});
        chk("trst en", 4'h0, {3'h0, en});
        master.set_trst(1'b1);
        seq(32'h5, 5);
        repeat (33) go(1'b0, 1'b1);
        nl = n_loads;
        seq(32'h1F, 5);
        repeat (6) @(negedge clk);
        chk("end state", ST_RESET, st);
        chk("end en", 4'h0, {3'h0, en});
        chk("id loads", 4'h1, 4'(n_loads - nl));
        conclude();
    end
endmodule : tap_controller_reset_fsm_tb
`default_nettype wire
